// [rtl/coc_byte_reg.sv]
// One 8-bit control register with per-bit storage mask and reset value
`default_nettype none
module coc_byte_reg
  import coc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK     = 8'hff
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output var  logic [7:0] q
);
  // Masked storage; unmasked bits stay at zero so reserved positions cost nothing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= RESET_VAL & WMASK;
    end else if (wr_en) begin
      q <= wr_data & WMASK;
    end
  end
endmodule : coc_byte_reg
`default_nettype wire

// [rtl/coc_clock_output_ctrl.sv]
// Control registers for the second differential, reference and low-rate outputs
`default_nettype none
module coc_clock_output_ctrl
  import coc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire coc_req_t   req,
  output var  logic [7:0] rd_data_q,
  output var  logic       rd_valid_q,
  output var  coc_ctl_t   ctl_q
);
  logic [7:0]    diff2_q;
  logic [7:0]    se_div_q;
  logic [7:0]    diff2_wdata;
  logic          diff2_wr;
  logic          se_div_wr;
  coc_sig_type_t wr_type;
  coc_ctl_t      ctl_d;

  // Address decode; writes to unmapped offsets are dropped
  assign diff2_wr  = req.wr && (req.addr == COC_DIFF2_CTRL_OFS);
  assign se_div_wr = req.wr && (req.addr == COC_SE_DIV_CTRL_OFS);

  // A reserved type code keeps the previous type; the rest of the byte still lands
  assign wr_type = coc_sig_type_t'(req.wdata[COC_D2_TYPE_HI:COC_D2_TYPE_LO]);
  always_comb begin
    diff2_wdata = req.wdata;
    if (wr_type == COC_TYPE_RSVD1 || wr_type == COC_TYPE_RSVD2) begin
      diff2_wdata[COC_D2_TYPE_HI:COC_D2_TYPE_LO] = diff2_q[COC_D2_TYPE_HI:COC_D2_TYPE_LO];
    end
  end

  // Second differential output control storage
  coc_byte_reg #(
    .RESET_VAL (COC_DIFF2_RESET),
    .WMASK     (COC_DIFF2_WMASK)
  ) u_diff2 (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (diff2_wr),
    .wr_data (diff2_wdata),
    .q       (diff2_q)
  );

  // Single-ended and divider control storage
  coc_byte_reg #(
    .RESET_VAL (COC_SE_DIV_RESET),
    .WMASK     (COC_SE_DIV_WMASK)
  ) u_se_div (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (se_div_wr),
    .wr_data (req.wdata),
    .q       (se_div_q)
  );

  // Read path, one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req.rd;
      if (req.rd) begin
        case (req.addr)
          COC_DIFF2_CTRL_OFS:  rd_data_q <= diff2_q | COC_DIFF2_RSVD_RD;
          COC_SE_DIV_CTRL_OFS: rd_data_q <= se_div_q | COC_SE_DIV_RSVD_RD;
          default:             rd_data_q <= 8'h00;
        endcase
      end
    end
  end

  // Decode of stored fields into stage controls; power down gates every enable
  always_comb begin
    ctl_d = '0;
    ctl_d.chip_power_down_n             = se_div_q[COC_PWR_N_BIT];
    ctl_d.second_diff_source_select     = diff2_q[COC_D2_SRC_BIT];
    ctl_d.second_diff_signal_type       =
      coc_sig_type_t'(diff2_q[COC_D2_TYPE_HI:COC_D2_TYPE_LO]);
    ctl_d.second_diff_single_slew       = diff2_q[COC_D2_SLEW_BIT];
    // Leg only matters in single-ended pair mode
    ctl_d.second_diff_complement_enable = diff2_q[COC_D2_COMP_BIT] && se_div_q[COC_PWR_N_BIT]
      && (diff2_q[COC_D2_TYPE_HI:COC_D2_TYPE_LO] == COC_TYPE_SINGLE);
    ctl_d.ref_output_enable             =
      se_div_q[COC_REF_EN_BIT] && se_div_q[COC_PWR_N_BIT];
    ctl_d.ref_free_run                  = se_div_q[COC_REF_FREE_BIT];
    ctl_d.lowrate_force_32k             = !se_div_q[COC_LR_32K_BIT];
    // Source select held low while the 32 kHz default owns the output
    ctl_d.lowrate_output_source_select  =
      se_div_q[COC_LR_32K_BIT] && se_div_q[COC_LR_SRC_BIT];
    ctl_d.fourth_divider_channel_three_enable =
      se_div_q[COC_CH3_EN_BIT] && se_div_q[COC_PWR_N_BIT];
    ctl_d.fourth_divider_channel_two_enable   =
      se_div_q[COC_CH2_EN_BIT] && se_div_q[COC_PWR_N_BIT];
  end

  // Registered outputs so the stage muxes never see decode glitches
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_q <= '0;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // Source select follows the written bit two cycles later
  diff_source_a: assert property (@(posedge ref_clk) disable iff (reset)
    diff2_wr |-> ##2 ctl_q.second_diff_source_select == $past(req.wdata[COC_D2_SRC_BIT], 2))
    else $error("second diff source select wrong");

  // Without a write the source mux must not move; its reset and default values agree
  source_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !diff2_wr |-> ##2 $stable(ctl_q.second_diff_source_select))
    else $error("second diff source select moved without a write");

  // Reserved type codes never reach storage
  type_no_rsvd_a: assert property (@(posedge ref_clk) disable iff (reset)
    diff2_wr && (wr_type == COC_TYPE_RSVD1 || wr_type == COC_TYPE_RSVD2)
    |=> $stable(diff2_q[COC_D2_TYPE_HI:COC_D2_TYPE_LO]))
    else $error("reserved type code stored");

  // Single-ended code written lands in the field
  type_single_a: assert property (@(posedge ref_clk) disable iff (reset)
    diff2_wr && wr_type == COC_TYPE_SINGLE
    |-> ##2 ctl_q.second_diff_signal_type == COC_TYPE_SINGLE)
    else $error("single-ended type not applied");

  // Slew follows its bit
  slew_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    diff2_wr |-> ##2 ctl_q.second_diff_single_slew == $past(req.wdata[COC_D2_SLEW_BIT], 2))
    else $error("slew drive wrong");

  // Slew holds between writes
  slew_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !diff2_wr |-> ##2 $stable(ctl_q.second_diff_single_slew))
    else $error("slew drive moved without a write");

  // Complementary leg never on outside single-ended mode
  comp_mode_a: assert property (@(posedge ref_clk) disable iff (reset)
    ctl_q.second_diff_complement_enable |-> ctl_q.second_diff_signal_type == COC_TYPE_SINGLE)
    else $error("complement leg on outside single-ended mode");

  // Leg follows its bit in single-ended mode while power stays on and untouched
  comp_follow_a: assert property (@(posedge ref_clk) disable iff (reset)
    diff2_wr && wr_type == COC_TYPE_SINGLE && se_div_q[COC_PWR_N_BIT] && !se_div_wr
    |-> ##2 ctl_q.second_diff_complement_enable == $past(req.wdata[COC_D2_COMP_BIT], 2))
    else $error("complement leg does not follow its bit");

  // Powering down drops the reference enable and both divider channel enables
  power_down_a: assert property (@(posedge ref_clk) disable iff (reset)
    !ctl_q.chip_power_down_n |-> !ctl_q.ref_output_enable
      && !ctl_q.fourth_divider_channel_three_enable && !ctl_q.fourth_divider_channel_two_enable)
    else $error("enable active during power down");

  // Power bit written low reaches the output in two cycles
  power_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr && !req.wdata[COC_PWR_N_BIT] |-> ##2 !ctl_q.chip_power_down_n)
    else $error("power down not applied");

  // 32 kHz default excludes a divider choice
  lowrate_32k_a: assert property (@(posedge ref_clk) disable iff (reset)
    ctl_q.lowrate_force_32k |-> !ctl_q.lowrate_output_source_select)
    else $error("low-rate source chosen under 32k default");

  // Forced 32 kHz is bit 4 cleared
  force_32k_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.lowrate_force_32k == !$past(req.wdata[COC_LR_32K_BIT], 2))
    else $error("low-rate 32k default wrong");

  // Divider choice reaches the mux only once the default is released
  lowrate_source_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.lowrate_output_source_select
      == ($past(req.wdata[COC_LR_32K_BIT], 2) && $past(req.wdata[COC_LR_SRC_BIT], 2)))
    else $error("low-rate source select wrong");

  // Channel three enable tracks its bit under power
  ch_three_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.fourth_divider_channel_three_enable
      == ($past(req.wdata[COC_CH3_EN_BIT], 2) && $past(req.wdata[COC_PWR_N_BIT], 2)))
    else $error("channel three enable wrong");

  // Channel two enable tracks its bit under power
  ch_two_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.fourth_divider_channel_two_enable
      == ($past(req.wdata[COC_CH2_EN_BIT], 2) && $past(req.wdata[COC_PWR_N_BIT], 2)))
    else $error("channel two enable wrong");

  // Reference free-run follows its bit
  ref_free_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.ref_free_run == $past(req.wdata[COC_REF_FREE_BIT], 2))
    else $error("reference free-run wrong");

  // Reference enable tracks its bit under power
  ref_enable_a: assert property (@(posedge ref_clk) disable iff (reset)
    se_div_wr |-> ##2 ctl_q.ref_output_enable
      == ($past(req.wdata[COC_REF_EN_BIT], 2) && $past(req.wdata[COC_PWR_N_BIT], 2)))
    else $error("reference enable wrong");

  // Free-run holds between writes
  ref_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    !se_div_wr |-> ##2 $stable(ctl_q.ref_free_run))
    else $error("reference free-run moved without a write");

  // Read answer one cycle after the strobe
  read_answer_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.rd && req.addr == COC_SE_DIV_CTRL_OFS && !req.wr
    |=> rd_valid_q && rd_data_q == $past(se_div_q))
    else $error("register read answer wrong");

  // Second differential register reads storage with the reserved one forced in
  read_diff2_a: assert property (@(posedge ref_clk) disable iff (reset)
    req.rd && req.addr == COC_DIFF2_CTRL_OFS && !req.wr
    |=> rd_valid_q && rd_data_q == ($past(diff2_q) | COC_DIFF2_RSVD_RD))
    else $error("second diff register read wrong");
endmodule : coc_clock_output_ctrl
`default_nettype wire

// [rtl/coc_pkg.sv]
// Package of offsets, field positions, reset values and carriers for the clock output controls
`default_nettype none
package coc_pkg;
  // Register offsets on the configuration port
  localparam logic [7:0] COC_DIFF2_CTRL_OFS   = 8'h23;
  localparam logic [7:0] COC_SE_DIV_CTRL_OFS  = 8'h24;

  // Second differential output control field positions
  localparam int COC_D2_SRC_BIT      = 7;
  localparam int COC_D2_TYPE_HI      = 5;
  localparam int COC_D2_TYPE_LO      = 4;
  localparam int COC_D2_SLEW_BIT     = 1;
  localparam int COC_D2_COMP_BIT     = 0;

  // Single-ended and divider control field positions
  localparam int COC_PWR_N_BIT       = 7;
  localparam int COC_REF_FREE_BIT    = 6;
  localparam int COC_LR_32K_BIT      = 4;
  localparam int COC_LR_SRC_BIT      = 3;
  localparam int COC_REF_EN_BIT      = 2;
  localparam int COC_CH3_EN_BIT      = 1;
  localparam int COC_CH2_EN_BIT      = 0;

  // Values after reset of the storage bits
  localparam logic [7:0] COC_DIFF2_RESET  = 8'h30;
  localparam logic [7:0] COC_SE_DIV_RESET = 8'h8c;

  // Writable bits; reserved positions hold no storage
  localparam logic [7:0] COC_DIFF2_WMASK  = 8'hb3;
  localparam logic [7:0] COC_SE_DIV_WMASK = 8'hdf;

  // Constant read value of reserved bits
  localparam logic [7:0] COC_DIFF2_RSVD_RD  = 8'h04;
  localparam logic [7:0] COC_SE_DIV_RSVD_RD = 8'h00;

  // Signalling type codes of the second differential output
  typedef enum logic [1:0] {
    COC_TYPE_SINGLE = 2'b00,
    COC_TYPE_RSVD1  = 2'b01,
    COC_TYPE_RSVD2  = 2'b10,
    COC_TYPE_DIFF   = 2'b11
  } coc_sig_type_t;

  // Register access request from the serial management port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } coc_req_t;

  // Controls toward the clock output stages
  typedef struct packed {
    logic          second_diff_source_select;
    coc_sig_type_t second_diff_signal_type;
    logic          second_diff_single_slew;
    logic          second_diff_complement_enable;
    logic          chip_power_down_n;
    logic          ref_output_enable;
    logic          ref_free_run;
    logic          lowrate_force_32k;
    logic          lowrate_output_source_select;
    logic          fourth_divider_channel_three_enable;
    logic          fourth_divider_channel_two_enable;
  } coc_ctl_t;
endpackage : coc_pkg
`default_nettype wire

// [test/coc_host_model.sv]
// Host model issuing byte writes and reads on the register port
`default_nettype none
module coc_host_model
  import coc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_data_q,
  input  wire logic       rd_valid_q,
  output var  coc_req_t   req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // One-cycle write strobe; released fields are scrambled, not held
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Read strobe, then a bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      ok = (rd_valid_q === 1'b1);
      d = rd_data_q;
      if (!ok) @(posedge ref_clk);
    end
  endtask
endmodule // coc_host_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the clock output control registers
`default_nettype none
module tb
  import coc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  coc_req_t   req;
  logic [7:0] rd_data_q;
  logic       rd_valid_q;
  coc_ctl_t   ctl_q;
  int         fail_count = 0;
  int         n_compared = 0;
  logic [7:0] s23 = COC_DIFF2_RESET;
  logic [7:0] s24 = COC_SE_DIV_RESET;

  coc_clock_output_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .req(req),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .ctl_q(ctl_q));
  coc_host_model host (.ref_clk(ref_clk), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .req(req));

  // 25 MHz clock
  initial forever #20 ref_clk = ~ref_clk;

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkc(string nm);
    logic [7:0] a;
    logic [7:0] b;
    logic       p;
    coc_ctl_t   e;
    a = s23;
    b = s24;
    p = b[7];
    // Power bit gates legs and enables; selects and flags stay ungated
    e = '{a[7], coc_sig_type_t'(a[5:4]), a[1], a[0] & (a[5:4] == 2'b00) & p, p,
          b[2] & p, b[6], ~b[4], b[4] & b[3], b[1] & p, b[0] & p};
    n_compared++;
    if (ctl_q !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, ctl_q);
    end
  endtask
  // Write through the host and track storage; reserved type codes keep the old field
  task automatic put(logic [7:0] a, logic [7:0] d);
    if (a == COC_DIFF2_CTRL_OFS)
      s23 = (d[5:4] == 2'b01 || d[5:4] == 2'b10) ? {d[7:6], s23[5:4], d[3:0]} : d;
    if (a == COC_SE_DIV_CTRL_OFS) s24 = d;
    host.wr(a, d);
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rchk(string nm, logic [7:0] a);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    // A missing answer ends the run through the single verdict
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %s expected valid seen none", nm);
      give_verdict();
    end else if (a == COC_DIFF2_CTRL_OFS) begin
      chk8(nm, (s23 & COC_DIFF2_WMASK) | COC_DIFF2_RSVD_RD, d);
    end else if (a == COC_SE_DIV_CTRL_OFS) begin
      chk8(nm, s24 & COC_SE_DIV_WMASK, d);
    end else begin
      chk8(nm, 8'h00, d);
    end
  endtask

  task automatic t_defaults();
    chkc("ctl after reset");
    rchk("read 23 default", COC_DIFF2_CTRL_OFS);
    rchk("read 24 default", COC_SE_DIV_CTRL_OFS);
    $display("test defaults done");
  endtask
  task automatic t_diff2();
    put(COC_DIFF2_CTRL_OFS, 8'h83);
    chkc("single-ended pair");
    put(COC_DIFF2_CTRL_OFS, 8'h31);
    chkc("leg off in differential mode");
    put(COC_DIFF2_CTRL_OFS, 8'h11);
    chkc("reserved code 01");
    put(COC_DIFF2_CTRL_OFS, 8'ha2);
    chkc("reserved code 10");
    rchk("read 23 after writes", COC_DIFF2_CTRL_OFS);
    $display("test diff2 done");
  endtask
  task automatic t_lowrate();
    put(COC_SE_DIV_CTRL_OFS, 8'hdb);
    chkc("divider selects");
    put(COC_SE_DIV_CTRL_OFS, 8'h13);
    chkc("power down gating");
    put(COC_SE_DIV_CTRL_OFS, 8'hef);
    chkc("forced 32k");
    rchk("read 24 after writes", COC_SE_DIV_CTRL_OFS);
    $display("test lowrate done");
  endtask
  task automatic t_unmapped();
    put(8'h25, 8'hff);
    rchk("read unmapped", 8'h25);
    chkc("ctl after unmapped write");
    // Second reset in mid-run restores defaults
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    s23 = COC_DIFF2_RESET;
    s24 = COC_SE_DIV_RESET;
    @(posedge ref_clk);
    #1;
    chkc("ctl after second reset");
    $display("test unmapped done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_defaults();
    t_diff2();
    t_lowrate();
    t_unmapped();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
